//--- design/cecb_chan_sup.sv
`timescale 1ns/1ps
`default_nettype none
module cecb_chan_sup
(
	input  wire logic                       sys_clk,         // Peripheral clock, 20 MHz.
	input  wire logic                       resetn,          // Synchronous reset, active low.
	input  wire logic [cecb_pkg::ADDR_W-1:0] avs_address,    // Byte address.
	input  wire logic                       avs_read,        // Read request.
	input  wire logic                       avs_write,       // Write request.
	input  wire logic [3:0]                 avs_byteenable,  // Write byte lanes.
	input  wire logic [cecb_pkg::DATA_W-1:0] avs_writedata,  // Write data.
	output logic      [cecb_pkg::DATA_W-1:0] avs_readdata,   // Read data.
	output logic                            avs_waitrequest, // Stall while high.
	input  wire logic                       can_rx,          // Receive pin from transceiver.
	input  wire logic                       bit_tick,        // Bit sample point pulse.
	input  wire logic                       tx_mon,          // Bit monitoring active this bit.
	input  wire logic                       tx_bit,          // Level being driven this bit.
	input  wire logic [4:0]                 proto_err,       // Ack-delim, crc, ack, form, stuff.
	input  wire logic [7:0]                 rx_err_cnt,      // Receive error counter.
	input  wire logic [8:0]                 tx_err_cnt,      // Transmit error counter.
	input  wire logic                       overload_det,    // Overload condition pulse.
	input  wire logic                       arb_lost,        // Arbitration lost pulse.
	input  wire logic                       tx_abort_done,   // Transmit abort complete pulse.
	input  wire logic                       tx_done_req,     // Transmit complete request.
	input  wire logic                       fifo_tx_req,     // FIFO transmit complete request.
	input  wire logic                       tx_hist_req,     // Transmit history request.
	input  wire logic                       store_start,     // Receive buffer store begins.
	input  wire logic [3:0]                 store_idx,       // Target receive buffer.
	input  wire logic [31:0]                store_word,      // Message word to store.
	output logic      [1:0]                 chan_mode,       // Current channel mode.
	output logic                            busoff,          // Channel in bus-off.
	output logic                            chan_err_irq,    // Channel error interrupt.
	output logic                            chan_tx_irq      // Channel transmit interrupt.
);
	import cecb_pkg::*;

	logic              ack_q;
	logic [31:0]       rdata_q;
	logic [2:0]        rx_sync_q;
	logic              rx_q;
	logic [1:0]        mode_q;
	logic [1:0]        policy_q;
	logic              disp_all_q;
	logic              abort_ie_q;
	logic [NUM_SRC-1:0] ie_q;
	logic [14:0]       errf_q;
	logic              abort_q;
	cecb_bo_e          bo_q;
	logic [3:0]        run_q;
	logic [7:0]        occ_q;
	logic [5:0]        lock_q;
	logic              supp_q;
	logic              pend_q;
	logic              warn_q;
	logic              pass_q;
	logic [31:0]       rxmem [NUM_RXBUF];
	logic [15:0]       new_q;
	logic [3:0]        stor_cnt_q;
	logic [3:0]        stor_idx_q;
	logic [3:0]        rx_sel_q;
	logic              err_irq_q;
	logic              tx_irq_q;

	// Bus decode: one wait state, writes land on the edge after the wait, which completes the transfer.
	wire        req      = avs_read | avs_write;
	wire        wr_en    = avs_write & ack_q;
	wire [31:0] be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [31:0] wd       = avs_writedata & be_mask;
	wire        wr_ctl_l = wr_en & (avs_address == OFS_CTRL_LOW);
	wire        wr_ctl_h = wr_en & (avs_address == OFS_CTRL_HIGH);
	wire        wr_errf  = wr_en & (avs_address == OFS_ERR_FLAG);
	wire        wr_ie    = wr_en & (avs_address == OFS_ERR_IE) & avs_byteenable[0];
	wire        wr_txs   = wr_en & (avs_address == OFS_TX_STAT) & avs_byteenable[0];
	wire        wr_new   = wr_en & (avs_address == OFS_RX_NEW);
	wire        wr_sel   = wr_en & (avs_address == OFS_RX_SEL) & avs_byteenable[0];

	// Software requests carried by chan_ctrl_low.
	wire        mode_wr   = wr_ctl_l & avs_byteenable[0];
	wire [1:0]  mode_wd   = avs_writedata[1:0];
	wire        force_wr  = mode_wr & avs_writedata[POS_FORCE_RET];
	wire        in_bo     = (bo_q == BO_OFF);
	wire        sw_reset  = mode_wr & (mode_wd == MODE_RESET);
	wire        sw_halt   = mode_wr & (mode_wd == MODE_HALT);
	wire        hold_halt = in_bo & sw_halt & (policy_q == POL_ISO);

	// Recessive-run and occurrence counting toward recovery.
	wire        rec_bit   = bit_tick & rx_q;
	wire        eleven    = in_bo & rec_bit & (run_q == RUN_LAST);
	wire        recovered = eleven & (occ_q == OCC_LAST);
	wire        force_ret = in_bo & force_wr;
	wire        enter_bo  = ~in_bo & (tx_err_cnt > LIM_BUSOFF);

	// Recovery interrupt is dropped for reset mode, policy 01 or a program halt.
	wire        supp_now  = supp_q | sw_reset | ((policy_q == POL_PROG) & sw_halt);
	wire        rec_ev    = recovered & ~supp_now;

	// Automatic halt may only start from communication mode.
	wire        auto_halt = (mode_q == MODE_COMM) &
		((enter_bo & (policy_q == POL_ENTRY)) |
		(recovered & ((policy_q == POL_END) | ((policy_q == POL_ISO) & pend_q))));
	wire [1:0]  mode_d    = (mode_wr & ~hold_halt) ? mode_wd :
		(auto_halt ? MODE_HALT : mode_q);

	// Counter thresholds, raised once per crossing from below.
	wire        warn_now   = ({1'b0, rx_err_cnt} > LIM_WARN) | (tx_err_cnt > LIM_WARN);
	wire        pass_now   = ({1'b0, rx_err_cnt} > LIM_PASSIVE) | (tx_err_cnt > LIM_PASSIVE);
	wire        warn_ev    = warn_now & ~warn_q;
	wire        pass_ev    = pass_now & ~pass_q;

	// Bus lock: the 32nd dominant bit in a row in communication mode.
	wire        lock_ev    = bit_tick & ~rx_q & (mode_q == MODE_COMM) & (lock_q == LOCK_LAST);

	// Bit errors come from comparing the driven level with the sampled one.
	wire        bit0_err   = bit_tick & tx_mon & ~tx_bit & rx_q;
	wire        bit1_err   = bit_tick & tx_mon & tx_bit & ~rx_q;
	wire [6:0]  bus_ev     = {proto_err[4], bit0_err, bit1_err, proto_err[3:0]};
	wire        first_free = (errf_q[14:8] == 7'h00);
	wire [6:0]  berr_set   = (disp_all_q | first_free) ? bus_ev : 7'h00;
	wire [NUM_SRC-1:0] src_ev = {arb_lost, lock_ev, overload_det, rec_ev,
		enter_bo, pass_ev, warn_ev, |bus_ev};
	wire [14:0] errf_clr   = wr_errf ? (~avs_writedata[14:0] & be_mask[14:0]) : 15'h0000;
	wire [14:0] errf_d     = (errf_q & ~errf_clr) | {berr_set, src_ev};

	// Storage window: the buffer being written cannot have its flag cleared.
	wire        storing    = (stor_cnt_q != 4'h0);
	wire [15:0] store_bit  = store_start ? (16'h0001 << store_idx) : 16'h0000;
	wire [15:0] busy_bit   = (storing ? (16'h0001 << stor_idx_q) : 16'h0000) | store_bit;
	wire [15:0] new_clr    = wr_new ? (~avs_writedata[15:0] & be_mask[15:0] & ~busy_bit) :
		16'h0000;
	wire [15:0] new_d      = (new_q & ~new_clr) | store_bit;

	// Read-back multiplexer; unmapped addresses read zero.
	wire [31:0] rd_mux =
		(avs_address == OFS_CTRL_LOW)  ? {28'h0000000, abort_ie_q, 1'b0, mode_q} :
		(avs_address == OFS_CTRL_HIGH) ? {29'h00000000, disp_all_q, policy_q} :
		(avs_address == OFS_ERR_FLAG)  ? {17'h00000, errf_q} :
		(avs_address == OFS_ERR_IE)    ? {24'h000000, ie_q} :
		(avs_address == OFS_STATUS)    ? {28'h0000000, pend_q, in_bo, mode_q} :
		(avs_address == OFS_TX_STAT)   ? {31'h00000000, abort_q} :
		(avs_address == OFS_RX_NEW)    ? {16'h0000, new_q} :
		(avs_address == OFS_RX_SEL)    ? {28'h0000000, rx_sel_q} :
		(avs_address == OFS_RX_DATA)   ? rxmem[rx_sel_q] : 32'h00000000;

	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata    = rdata_q;
	assign chan_mode       = mode_q;
	assign busoff          = in_bo;
	assign chan_err_irq    = err_irq_q;
	assign chan_tx_irq     = tx_irq_q;

	// Bus slave handshake; read data is captured during the wait state.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (avs_read & ~ack_q)
			begin
				rdata_q <= rd_mux;
			end
		end
	end

	// Pin synchroniser; the level moves only when the last two stages agree.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			rx_sync_q <= 3'h7;
			rx_q      <= 1'b1;
		end
		else
		begin
			rx_sync_q <= {rx_sync_q[1:0], can_rx};
			if (rx_sync_q[1] == rx_sync_q[2])
			begin
				rx_q <= rx_sync_q[2];
			end
		end
	end

	// Control registers written by software.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			mode_q     <= RST_MODE;
			policy_q   <= RST_POLICY;
			disp_all_q <= 1'b0;
			abort_ie_q <= 1'b0;
			ie_q       <= 8'h00;
			rx_sel_q   <= 4'h0;
		end
		else
		begin
			mode_q <= mode_d;
			if (wr_ctl_l & avs_byteenable[0])
			begin
				abort_ie_q <= avs_writedata[POS_ABORT_IE];
			end
			if (wr_ctl_h & avs_byteenable[0])
			begin
				policy_q   <= avs_writedata[1:0];
				disp_all_q <= avs_writedata[POS_ERR_DISP];
			end
			if (wr_ie)
			begin
				ie_q <= wd[NUM_SRC-1:0];
			end
			if (wr_sel)
			begin
				rx_sel_q <= wd[3:0];
			end
		end
	end

	// Bus-off state. A forced return or a reset request leaves it silently,
	// which keeps software from taking a recovery interrupt it did not wait for.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			bo_q   <= BO_ACTIVE;
			supp_q <= 1'b0;
			pend_q <= 1'b0;
		end
		else
		begin
			case (bo_q)
				BO_ACTIVE:
				begin
					pend_q <= 1'b0;
					if (enter_bo)
					begin
						bo_q   <= BO_OFF;
						supp_q <= (policy_q == POL_ENTRY);
					end
				end
				BO_OFF:
				begin
					supp_q <= supp_now;
					if (hold_halt)
					begin
						pend_q <= 1'b1;
					end
					if (recovered | force_ret | sw_reset)
					begin
						bo_q <= BO_ACTIVE;
					end
				end
				default:
				begin
					bo_q <= BO_ACTIVE;
				end
			endcase
		end
	end

	// Bit-level counters on the sample point.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			run_q  <= 4'h0;
			occ_q  <= 8'h00;
			lock_q <= 6'h00;
		end
		else
		begin
			if (!in_bo)
			begin
				run_q <= 4'h0;
				occ_q <= 8'h00;
			end
			else if (bit_tick)
			begin
				run_q <= (!rx_q || eleven) ? 4'h0 : run_q + 4'h1;
				occ_q <= eleven ? occ_q + 8'h01 : occ_q;
			end
			if (bit_tick)
			begin
				lock_q <= (rx_q || mode_q != MODE_COMM || lock_q == LOCK_LAST) ? 6'h00 :
					lock_q + 6'h01;
			end
		end
	end

	// Flags; a set in the cycle of a clear wins.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			errf_q  <= 15'h0000;
			abort_q <= 1'b0;
			warn_q  <= 1'b0;
			pass_q  <= 1'b0;
		end
		else
		begin
			errf_q  <= errf_d;
			abort_q <= tx_abort_done | (abort_q & ~(wr_txs & ~avs_writedata[0]));
			warn_q  <= warn_now;
			pass_q  <= pass_now;
		end
	end

	// Interrupt outputs, registered to keep them glitch free.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			err_irq_q <= 1'b0;
			tx_irq_q  <= 1'b0;
		end
		else
		begin
			err_irq_q <= |(errf_q[NUM_SRC-1:0] & ie_q);
			tx_irq_q  <= (abort_q & abort_ie_q) | tx_done_req | fifo_tx_req | tx_hist_req;
		end
	end

	// Receive buffers: always the latest message, and no interrupt on store.
	always_ff @(posedge sys_clk)
	begin
		if (store_start)
		begin
			rxmem[store_idx] <= store_word;
		end
	end

	// New-message flags and the storage window.
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			new_q      <= 16'h0000;
			stor_cnt_q <= 4'h0;
			stor_idx_q <= 4'h0;
		end
		else
		begin
			new_q <= new_d;
			if (store_start)
			begin
				stor_cnt_q <= STORE_CYC - 4'h1;
				stor_idx_q <= store_idx;
			end
			else if (storing)
			begin
				stor_cnt_q <= stor_cnt_q - 4'h1;
			end
		end
	end

endmodule // cecb_chan_sup
`default_nettype wire

//--- include/cecb_pkg.sv
package cecb_pkg;

	// Register bus geometry.
	localparam int          ADDR_W = 8;
	localparam int          DATA_W = 32;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL_LOW  = 8'h00;
	localparam logic [7:0] OFS_CTRL_HIGH = 8'h04;
	localparam logic [7:0] OFS_ERR_FLAG  = 8'h08;
	localparam logic [7:0] OFS_ERR_IE    = 8'h0c;
	localparam logic [7:0] OFS_STATUS    = 8'h10;
	localparam logic [7:0] OFS_TX_STAT   = 8'h14;
	localparam logic [7:0] OFS_RX_NEW    = 8'h18;
	localparam logic [7:0] OFS_RX_SEL    = 8'h1c;
	localparam logic [7:0] OFS_RX_DATA   = 8'h20;

	// Field positions in chan_ctrl_low and chan_ctrl_high.
	localparam int          POS_FORCE_RET = 2;
	localparam int          POS_ABORT_IE  = 3;
	localparam int          POS_ERR_DISP  = 2;

	// Source flag positions in chan_error_flag_reg, bus error flags at 14-8.
	localparam int          SRC_BUS_ERR  = 0;
	localparam int          SRC_WARN     = 1;
	localparam int          SRC_PASSIVE  = 2;
	localparam int          SRC_BO_ENTRY = 3;
	localparam int          SRC_BO_REC   = 4;
	localparam int          SRC_OVERLOAD = 5;
	localparam int          SRC_LOCK     = 6;
	localparam int          SRC_ARB_LOST = 7;
	localparam int          NUM_SRC      = 8;
	localparam int          POS_BERR_LO  = 8;
	localparam int          NUM_BERR     = 7;

	// Channel mode codes and bus-off recovery policies.
	localparam logic [1:0] MODE_COMM  = 2'h0;
	localparam logic [1:0] MODE_RESET = 2'h1;
	localparam logic [1:0] MODE_HALT  = 2'h2;
	localparam logic [1:0] POL_ISO    = 2'h0;
	localparam logic [1:0] POL_ENTRY  = 2'h1;
	localparam logic [1:0] POL_END    = 2'h2;
	localparam logic [1:0] POL_PROG   = 2'h3;

	// Error counter thresholds.
	localparam logic [8:0] LIM_WARN    = 9'h05f;
	localparam logic [8:0] LIM_PASSIVE = 9'h07f;
	localparam logic [8:0] LIM_BUSOFF  = 9'h0ff;

	// Bit counts on the bus and storage length in clock cycles.
	localparam logic [3:0] RUN_LAST   = 4'ha;
	localparam logic [7:0] OCC_LAST   = 8'h7f;
	localparam logic [5:0] LOCK_LAST  = 6'h1f;
	localparam logic [3:0] STORE_CYC  = 4'ha;
	localparam int          NUM_RXBUF = 16;

	// Reset values.
	localparam logic [1:0] RST_MODE   = MODE_RESET;
	localparam logic [1:0] RST_POLICY = POL_ISO;

	typedef enum logic {BO_ACTIVE, BO_OFF} cecb_bo_e;

endpackage

//--- verif/cecb_chan_sup_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cecb_chan_sup_checker
(
	input wire logic                        sys_clk,         // Clock.
	input wire logic                        resetn,          // Reset, active low.
	input wire logic [cecb_pkg::ADDR_W-1:0] avs_address,     // Byte address.
	input wire logic                        avs_read,        // Read request.
	input wire logic                        avs_write,       // Write request.
	input wire logic [cecb_pkg::DATA_W-1:0] avs_writedata,   // Write data.
	input wire logic                        avs_waitrequest, // Stall.
	input wire logic                        bit_tick,        // Sample point.
	input wire logic [8:0]                  tx_err_cnt,      // Transmit errors.
	input wire logic                        tx_done_req,     // Transmit done.
	input wire logic                        fifo_tx_req,     // FIFO done.
	input wire logic                        tx_hist_req,     // History.
	input wire logic [1:0]                  chan_mode,       // Mode.
	input wire logic                        busoff,          // Bus-off.
	input wire logic                        chan_err_irq,    // Error irq.
	input wire logic                        chan_tx_irq      // Transmit irq.
);
	import cecb_pkg::*;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// Accepted write to the control word that carries the mode field.
	wire logic ctl_wr = avs_write && !avs_waitrequest && avs_address == OFS_CTRL_LOW;
	logic [11:0] tick_q;
	// Ticks since bus-off began; saturates so a stuck channel cannot wrap it.
	always_ff @(posedge sys_clk)
		if (!busoff)
			tick_q <= 12'h000;
		else if (bit_tick && tick_q != 12'hfff)
			tick_q <= tick_q + 12'h001;
	a_wait_bound: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not one cycle after request");
	a_busoff_entry: assert property (tx_err_cnt > LIM_BUSOFF && !busoff && !ctl_wr |=> busoff)
		else $error("bus-off not entered");
	// The sampled count stops one short: the tick that completes recovery is not yet in it.
	a_recover_len: assert property ($fell(busoff) && !$past(ctl_wr) |-> $past(tick_q) >= 12'h57f)
		else $error("bus-off left too early");
	a_tx_or: assert property (tx_done_req || fifo_tx_req || tx_hist_req |=> chan_tx_irq)
		else $error("transmit interrupt missing");
	a_auto_halt: assert property ($rose(chan_mode == MODE_HALT) && !$past(ctl_wr) |-> $past(chan_mode) == MODE_COMM)
		else $error("automatic halt outside communication");
	a_sw_mode: assert property (ctl_wr && !busoff && avs_writedata[1:0] != 2'h3 |=> chan_mode == $past(avs_writedata[1:0]))
		else $error("mode write lost");
	a_reset_exit: assert property (ctl_wr && busoff && avs_writedata[1:0] == MODE_RESET |=> !busoff && chan_mode == MODE_RESET)
		else $error("reset mode did not end bus-off");
	a_force_exit: assert property (ctl_wr && busoff && avs_writedata[POS_FORCE_RET] |=> !busoff)
		else $error("forced return ignored");
	cover property ($rose(busoff));
	cover property ($fell(busoff));
	cover property ($rose(chan_err_irq));
endmodule // cecb_chan_sup_checker
bind cecb_chan_sup cecb_chan_sup_checker u_chk (.sys_clk, .resetn, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_waitrequest, .bit_tick, .tx_err_cnt, .tx_done_req,
	.fifo_tx_req, .tx_hist_req, .chan_mode, .busoff, .chan_err_irq, .chan_tx_irq);
`default_nettype wire

//--- verif/cecb_can_node.sv
`timescale 1ns/1ps
`default_nettype none
module cecb_can_node
(
	input  wire logic dom_req,         // Bench asks for dominant bits.
	input  wire logic sys_clk,         // Clock.
	output logic      can_rx = 1'b1,   // Bus level, 1 is recessive.
	output logic      bit_tick = 1'b0  // Sample point pulse.
);
	logic [2:0] cnt_q = 3'h0;
	// Six clocks a bit; the level changes at bit start and is sampled five clocks
	// later, which leaves room for the receiver's synchroniser.
	always_ff @(posedge sys_clk)
	begin
		cnt_q    <= (cnt_q == 3'h5) ? 3'h0 : cnt_q + 3'h1;
		bit_tick <= cnt_q == 3'h4;
		if (cnt_q == 3'h5)
			can_rx <= ~dom_req;
	end
endmodule // cecb_can_node
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cecb_pkg::*;
	logic        sys_clk, resetn, avs_read, avs_write, can_rx, bit_tick, dom_req, tx_mon;
	logic        tx_bit, overload_det, arb_lost, tx_abort_done, tx_done_req, fifo_tx_req;
	logic        tx_hist_req, store_start, busoff, chan_err_irq, chan_tx_irq, avs_waitrequest;
	logic [1:0]  chan_mode;
	logic [3:0]  store_idx;
	logic [4:0]  proto_err;
	logic [7:0]  avs_address, rx_err_cnt;
	logic [8:0]  tx_err_cnt;
	logic [31:0] avs_writedata, avs_readdata, store_word, rd_q;
	int          num_errors, tests_run;
	cecb_chan_sup DUT (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write,
		.avs_byteenable(4'hf), .avs_writedata, .avs_readdata, .avs_waitrequest, .can_rx,
		.bit_tick, .tx_mon, .tx_bit, .proto_err, .rx_err_cnt, .tx_err_cnt, .overload_det,
		.arb_lost, .tx_abort_done, .tx_done_req, .fifo_tx_req, .tx_hist_req, .store_start,
		.store_idx, .store_word, .chan_mode, .busoff, .chan_err_irq, .chan_tx_irq);
	cecb_can_node u_node (.dom_req, .sys_clk, .can_rx, .bit_tick);
	// Free running 20 MHz clock.
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic stop_test;
		$display("mismatches %0d, checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic hang;
		num_errors++;
		stop_test;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// One bus transfer; entered just after a rising edge, leaves one edge idle after.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		// Waitrequest and read data are both taken at the rising edge itself.
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20)
			hang;
		rd_q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd_q, exp);
	endtask
	// Interrupt outputs are looked at mid-cycle, where they have settled.
	task automatic irq_chk(input logic [1:0] exp);
		@(negedge sys_clk);
		chk({30'h0, chan_tx_irq, chan_err_irq}, {30'h0, exp});
		@(posedge sys_clk);
	endtask
	task automatic t_errors;
		xfer(1'b1, OFS_ERR_FLAG, 32'h0);
		proto_err <= 5'h08;
		cyc(1);
		proto_err <= 5'h01;
		cyc(1);
		proto_err <= 5'h00;
		cyc(3);
		rd_chk(OFS_ERR_FLAG, 32'h0801);
		irq_chk(2'b01);
		xfer(1'b1, OFS_ERR_FLAG, 32'h0);
		proto_err <= 5'h06;
		cyc(1);
		proto_err <= 5'h00;
		cyc(3);
		rd_chk(OFS_ERR_FLAG, 32'h0601);
		xfer(1'b1, OFS_ERR_IE, 32'h0);
		irq_chk(2'b00);
		xfer(1'b1, OFS_ERR_IE, 32'hff);
		xfer(1'b1, OFS_CTRL_HIGH, 32'h4);
		xfer(1'b1, OFS_ERR_FLAG, 32'h0);
		for (int i = 0; i < 5; i++)
		begin
			proto_err <= 5'h01 << i;
			cyc(1);
			proto_err <= 5'h00;
			cyc(1);
		end
		tx_mon <= 1'b1;
		cyc(14);
		tx_bit  <= 1'b1;
		dom_req <= 1'b1;
		cyc(20);
		tx_mon  <= 1'b0;
		dom_req <= 1'b0;
		cyc(14);
		rd_chk(OFS_ERR_FLAG, 32'h7f01);
	endtask
	task automatic t_events;
		xfer(1'b1, OFS_ERR_FLAG, 32'h0);
		rx_err_cnt <= 8'h60;
		cyc(3);
		rd_chk(OFS_ERR_FLAG, 32'h2);
		xfer(1'b1, OFS_ERR_FLAG, 32'h0);
		rx_err_cnt <= 8'h64;
		tx_err_cnt <= 9'h080;
		cyc(3);
		rd_chk(OFS_ERR_FLAG, 32'h4);
		rx_err_cnt <= 8'h00;
		tx_err_cnt <= 9'h000;
		xfer(1'b1, OFS_ERR_FLAG, 32'h0);
		overload_det <= 1'b1;
		arb_lost     <= 1'b1;
		cyc(1);
		overload_det <= 1'b0;
		arb_lost     <= 1'b0;
		cyc(3);
		rd_chk(OFS_ERR_FLAG, 32'ha0);
		xfer(1'b1, OFS_ERR_FLAG, 32'h0);
		dom_req <= 1'b1;
		cyc(204);
		dom_req <= 1'b0;
		cyc(12);
		rd_chk(OFS_ERR_FLAG, 32'h40);
	endtask
	task automatic t_tx_store;
		xfer(1'b1, OFS_ERR_FLAG, 32'h0);
		xfer(1'b1, OFS_CTRL_LOW, 32'h8);
		tx_abort_done <= 1'b1;
		cyc(1);
		tx_abort_done <= 1'b0;
		cyc(2);
		irq_chk(2'b10);
		xfer(1'b1, OFS_TX_STAT, 32'h0);
		xfer(1'b1, OFS_CTRL_LOW, 32'h0);
		tx_abort_done <= 1'b1;
		cyc(1);
		tx_abort_done <= 1'b0;
		cyc(2);
		irq_chk(2'b00);
		tx_done_req <= 1'b1;
		cyc(1);
		irq_chk(2'b10);
		tx_done_req <= 1'b0;
		fifo_tx_req <= 1'b1;
		cyc(1);
		irq_chk(2'b10);
		fifo_tx_req <= 1'b0;
		tx_hist_req <= 1'b1;
		cyc(1);
		irq_chk(2'b10);
		tx_hist_req <= 1'b0;
		xfer(1'b1, OFS_RX_SEL, 32'h3);
		store_idx   <= 4'h3;
		store_word  <= 32'h1111aaaa;
		store_start <= 1'b1;
		cyc(1);
		store_start <= 1'b0;
		xfer(1'b1, OFS_RX_NEW, 32'h0);
		rd_chk(OFS_RX_NEW, 32'h8);
		cyc(12);
		xfer(1'b1, OFS_RX_NEW, 32'h0);
		rd_chk(OFS_RX_NEW, 32'h0);
		store_word  <= 32'h22225555;
		store_start <= 1'b1;
		cyc(1);
		store_start <= 1'b0;
		cyc(12);
		rd_chk(OFS_RX_DATA, 32'h22225555);
		irq_chk(2'b00);
	endtask
	// Enter bus-off under a policy, apply a mode action, wait out recovery.
	task automatic bo_case(input logic [1:0] pol, input logic [31:0] act,
		input logic [1:0] mode, input logic [31:0] flags);
		int n;
		n = 0;
		xfer(1'b1, OFS_CTRL_LOW, 32'h0);
		xfer(1'b1, OFS_CTRL_HIGH, {30'h0, pol});
		xfer(1'b1, OFS_ERR_FLAG, 32'h0);
		tx_err_cnt <= 9'h100;
		cyc(2);
		tx_err_cnt <= 9'h000;
		if (act != 32'h0)
			xfer(1'b1, OFS_CTRL_LOW, act);
		if (act == 32'h2 && pol == POL_ISO)
			rd_chk(OFS_STATUS, 32'hc);
		while (busoff !== 1'b0 && n < 10000)
		begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 10000)
			hang;
		cyc(3);
		// Mode and bus-off pins are looked at mid-cycle, where they have settled.
		@(negedge sys_clk);
		chk({29'h0, busoff, chan_mode}, {29'h0, 1'b0, mode});
		@(posedge sys_clk);
		rd_chk(OFS_STATUS, {30'h0, mode});
		rd_chk(OFS_ERR_FLAG, flags);
	endtask
	// Main sequence.
	initial
	begin
		{avs_read, avs_write, tx_mon, tx_bit, overload_det, arb_lost, resetn} = '0;
		{tx_abort_done, tx_done_req, fifo_tx_req, tx_hist_req, store_start, dom_req} = '0;
		{avs_address, avs_writedata, store_idx, store_word, proto_err} = '0;
		{rx_err_cnt, tx_err_cnt, num_errors, tests_run} = '0;
		cyc(2);
		resetn <= 1'b1;
		rd_chk(OFS_STATUS, 32'h1);
		rd_chk(OFS_ERR_FLAG, 32'h0);
		rd_chk(8'h40, 32'h0);
		xfer(1'b1, OFS_CTRL_LOW, 32'h0);
		xfer(1'b1, OFS_ERR_IE, 32'hff);
		t_errors;
		t_events;
		t_tx_store;
		bo_case(POL_ENTRY, 32'h0, MODE_HALT, 32'h0e);
		bo_case(POL_END, 32'h0, MODE_HALT, 32'h1e);
		bo_case(POL_ISO, 32'h2, MODE_HALT, 32'h1e);
		bo_case(POL_PROG, 32'h2, MODE_HALT, 32'h0e);
		bo_case(POL_ISO, 32'h1, MODE_RESET, 32'h0e);
		bo_case(POL_ISO, 32'h4, MODE_COMM, 32'h0e);
		stop_test;
	end
endmodule // tb_top
`default_nettype wire
